// [hdl/pmr_regs.svh]
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMR_ADDR_PIN_STATE 8'h11
`define PMR_ADDR_DIRECTION 8'h12
`define PMR_ADDR_REDUCED 8'h13
`define PMR_ADDR_PULL_EN 8'h14
`define PMR_ADDR_PULL_POL 8'h15
`define PMR_ADDR_OPEN_DRAIN 8'h16
`define PMR_ADDR_ROUTING 8'h17

// ----------------------------------------
// Routing fields and reset values
// ----------------------------------------
`define PMR_CANA_LSB 0
`define PMR_CANC_LSB 2
`define PMR_SPI0_BIT 4
`define PMR_SPI1_BIT 5
`define PMR_SPI2_BIT 6
`define PMR_ROUTE_MASK 8'h7f
`define PMR_CFG_RST 8'h00
`endif

// [hdl/pmr_pkg.sv]
package pmr_pkg;
    typedef enum logic [2:0] {
        PMR_OWN_GPIO = 3'h0,
        PMR_OWN_SPI0 = 3'h1,
        PMR_OWN_CANA = 3'h3,
        PMR_OWN_CANB = 3'h2,
        PMR_OWN_CANC = 3'h6
    } pmr_owner_e;

    // Pad controls of the eight port pins
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] reduced;
        logic [7:0] pull_up;
        logic [7:0] pull_dn;
    } pmr_pad_s;

    // SPI0 lines in order MISO, MOSI, SCK, SS
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] out;
    } pmr_spi_s;
endpackage : pmr_pkg

// [hdl/pmr_port.sv]
`timescale 1ns/10ps
`include "pmr_regs.svh"
module pmr_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    output pmr_pkg::pmr_pad_s pads,
    input wire logic [7:0] gpio_data,
    input wire logic can_a_en,
    input wire logic can_a_transmit,
    output logic can_a_receive,
    input wire logic can_b_en,
    input wire logic can_b_transmit,
    output logic can_b_receive,
    input wire logic can_c_en,
    input wire logic can_c_transmit,
    output logic can_c_receive,
    output logic [1:0] can_c_route,
    input wire logic spi0_en,
    input wire pmr_pkg::pmr_spi_s spi0_drive,
    output logic [3:0] spi0_sense,
    output logic spi0_on_port_m,
    output logic spi1_on_port_h,
    output logic spi2_on_port_h
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] pin_state_reg;
    logic [7:0] pin_state_next;

    // A bit moves only once the last two stages agree, so a slow edge
    // cannot show a one-cycle glitch to software
    always_comb begin
        pin_state_next = (~(sync2_reg ^ sync3_reg) & sync3_reg)
                       | ((sync2_reg ^ sync3_reg) & pin_state_reg);
    end

    // No reset here: the pins are sampled throughout reset
    always_ff @(posedge sys_clk) begin
        sync1_reg <= pad_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        pin_state_reg <= pin_state_next;
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] dir_reg, dir_next;
    logic [7:0] rdr_reg, rdr_next;
    logic [7:0] pe_reg, pe_next;
    logic [7:0] pps_reg, pps_next;
    logic [7:0] od_reg, od_next;
    logic [7:0] route_reg, route_next;
    logic [7:0] rdata_next;

    always_comb begin
        dir_next = dir_reg;
        rdr_next = rdr_reg;
        pe_next = pe_reg;
        pps_next = pps_reg;
        od_next = od_reg;
        route_next = route_reg;
        if (reg_wr) begin
            // Writes to the pin-state offset fall through
            unique case (reg_addr)
                `PMR_ADDR_DIRECTION: dir_next = reg_wdata;
                `PMR_ADDR_REDUCED: rdr_next = reg_wdata;
                `PMR_ADDR_PULL_EN: pe_next = reg_wdata;
                `PMR_ADDR_PULL_POL: pps_next = reg_wdata;
                `PMR_ADDR_OPEN_DRAIN: od_next = reg_wdata;
                `PMR_ADDR_ROUTING: route_next = reg_wdata & `PMR_ROUTE_MASK;
                default: ;
            endcase
        end
        rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `PMR_ADDR_PIN_STATE: rdata_next = pin_state_reg;
                `PMR_ADDR_DIRECTION: rdata_next = dir_reg;
                `PMR_ADDR_REDUCED: rdata_next = rdr_reg;
                `PMR_ADDR_PULL_EN: rdata_next = pe_reg;
                `PMR_ADDR_PULL_POL: rdata_next = pps_reg;
                `PMR_ADDR_OPEN_DRAIN: rdata_next = od_reg;
                `PMR_ADDR_ROUTING: rdata_next = route_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dir_reg <= `PMR_CFG_RST;
            rdr_reg <= `PMR_CFG_RST;
            pe_reg <= `PMR_CFG_RST;
            pps_reg <= `PMR_CFG_RST;
            od_reg <= `PMR_CFG_RST;
            route_reg <= `PMR_CFG_RST;
            reg_rdata <= 8'h00;
        end else begin
            dir_reg <= dir_next;
            rdr_reg <= rdr_next;
            pe_reg <= pe_next;
            pps_reg <= pps_next;
            od_reg <= od_next;
            route_reg <= route_next;
            reg_rdata <= rdata_next;
        end
    end

    // Routing selects toward the other ports come straight from the register
    assign can_c_route = route_reg[`PMR_CANC_LSB +: 2];
    assign spi0_on_port_m = route_reg[`PMR_SPI0_BIT];
    assign spi1_on_port_h = route_reg[`PMR_SPI1_BIT];
    assign spi2_on_port_h = route_reg[`PMR_SPI2_BIT];

    // ----------------------------------------
    // Pin ownership and pad control
    // ----------------------------------------
    // SPI0 line serving port M pin i, order MISO, MOSI, SCK, SS
    function automatic logic [1:0] spi_slot(input int pin);
        unique case (pin)
            2: spi_slot = 2'h0;
            4: spi_slot = 2'h1;
            5: spi_slot = 2'h2;
            default: spi_slot = 2'h3;
        endcase
    endfunction : spi_slot

    pmr_pkg::pmr_owner_e own [8];
    logic [7:0] dir_eff;
    logic [7:0] dat_eff;
    logic [7:0] can_rx_mask;
    logic [7:0] pull_act;
    pmr_pkg::pmr_pad_s pads_next;
    logic rx_a_next, rx_b_next, rx_c_next;
    logic [3:0] sense_next;

    always_comb begin
        dir_eff = 8'h00;
        dat_eff = 8'h00;
        can_rx_mask = 8'h00;
        rx_a_next = 1'b1;
        rx_b_next = 1'b1;
        rx_c_next = 1'b1;
        sense_next = 4'h0;
        for (int i = 0; i < 8; i++) begin
            // Later tests win, so the order below is the priority
            own[i] = pmr_pkg::PMR_OWN_GPIO;
            if (spi0_en && route_reg[`PMR_SPI0_BIT] && i >= 2 && i <= 5) begin
                own[i] = pmr_pkg::PMR_OWN_SPI0;
            end
            if (can_c_en && i >= 4
                && route_reg[`PMR_CANC_LSB +: 2] == 2'((i >> 1) - 1)) begin
                own[i] = pmr_pkg::PMR_OWN_CANC;
            end
            if (can_a_en && i <= 5 && route_reg[`PMR_CANA_LSB +: 2] == 2'(i >> 1)) begin
                own[i] = pmr_pkg::PMR_OWN_CANA;
            end
            if (can_b_en && i <= 1) begin
                own[i] = pmr_pkg::PMR_OWN_CANB;
            end
            unique case (own[i])
                pmr_pkg::PMR_OWN_GPIO: begin
                    // Direction bits regain the pin once nobody else holds it
                    dir_eff[i] = dir_reg[i];
                    dat_eff[i] = gpio_data[i];
                end
                pmr_pkg::PMR_OWN_SPI0: begin
                    dir_eff[i] = spi0_drive.oe[spi_slot(i)];
                    dat_eff[i] = spi0_drive.out[spi_slot(i)];
                    sense_next[spi_slot(i)] = pin_state_reg[i];
                end
                pmr_pkg::PMR_OWN_CANA: begin
                    dir_eff[i] = i[0];
                    dat_eff[i] = i[0] & can_a_transmit;
                    if (!i[0]) rx_a_next = pin_state_reg[i];
                end
                pmr_pkg::PMR_OWN_CANB: begin
                    dir_eff[i] = i[0];
                    dat_eff[i] = i[0] & can_b_transmit;
                    if (!i[0]) rx_b_next = pin_state_reg[i];
                end
                pmr_pkg::PMR_OWN_CANC: begin
                    dir_eff[i] = i[0];
                    dat_eff[i] = i[0] & can_c_transmit;
                    if (!i[0]) rx_c_next = pin_state_reg[i];
                end
            endcase
            can_rx_mask[i] = own[i] != pmr_pkg::PMR_OWN_GPIO
                          && own[i] != pmr_pkg::PMR_OWN_SPI0 && !i[0];
        end
        // Open drain also covers peripheral outputs, so a bus of several
        // nodes can share the line
        pads_next.oe = dir_eff & ~(od_reg & dat_eff);
        pads_next.out = dat_eff & ~od_reg;
        pads_next.reduced = dir_eff & rdr_reg;
        pull_act = pe_reg & (~dir_eff | od_reg);
        pads_next.pull_up = pull_act & (~pps_reg | can_rx_mask);
        pads_next.pull_dn = pull_act & pps_reg & ~can_rx_mask;
    end

    // Receivers idle recessive (high) while not routed to port M
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pads <= '0;
            can_a_receive <= 1'b1;
            can_b_receive <= 1'b1;
            can_c_receive <= 1'b1;
            spi0_sense <= 4'h0;
        end else begin
            pads <= pads_next;
            can_a_receive <= rx_a_next;
            can_b_receive <= rx_b_next;
            can_c_receive <= rx_c_next;
            spi0_sense <= sense_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_pin_read;
        reg_rd && reg_addr == `PMR_ADDR_PIN_STATE |=> reg_rdata == $past(pin_state_reg);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin state read wrong");

    property p_pin_track;
        disable iff (1'b0)
        sync3_reg == sync2_reg ##1 sync3_reg == $past(sync3_reg) |-> pin_state_reg == sync3_reg;
    endproperty
    a_pin_track: assert property (p_pin_track) else $error("pin state stale");

    property p_gpio_input;
        own[7] == pmr_pkg::PMR_OWN_GPIO && !dir_reg[7] |=> !pads.oe[7] && !pads.reduced[7];
    endproperty
    a_gpio_input: assert property (p_gpio_input) else $error("input pin driven");

    property p_can_dir;
        can_a_en && !can_b_en && route_reg[1:0] == 2'h1 && !reg_wr
            |=> !pads.oe[2] && pads.oe[3] == !(od_reg[3] && $past(can_a_transmit))
                && $stable(dir_reg);
    endproperty
    a_can_dir: assert property (p_can_dir) else $error("CAN direction wrong");

    property p_release;
        $fell(can_b_en) && !(can_a_en && route_reg[1:0] == 2'h0) && !reg_wr
            |=> pads.oe[1] == ($past(dir_reg[1])
            && !($past(od_reg[1]) && $past(gpio_data[1])));
    endproperty
    a_release: assert property (p_release) else $error("pin not released");

    property p_pull_pp;
        ##1 ((pads.pull_up | pads.pull_dn) & $past(dir_eff & ~od_reg)) == 8'h00;
    endproperty
    a_pull_pp: assert property (p_pull_pp) else $error("pull on push-pull");

    property p_canrx_pull;
        ##1 (pads.pull_dn & $past(can_rx_mask)) == 8'h00;
    endproperty
    a_canrx_pull: assert property (p_canrx_pull) else $error("pull-down on CAN rx");

    property p_open_drain;
        ##1 (pads.oe & pads.out & $past(od_reg)) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

    property p_cana_route;
        can_a_en && !reg_wr && route_reg[1:0] == 2'h2 |=> can_a_receive == $past(pin_state_reg[4]);
    endproperty
    a_cana_route: assert property (p_cana_route) else $error("first CAN misrouted");

    property p_route_rw;
        reg_wr && reg_addr == `PMR_ADDR_ROUTING ##1 reg_rd && reg_addr == `PMR_ADDR_ROUTING
            |=> reg_rdata == ($past(reg_wdata, 2) & `PMR_ROUTE_MASK);
    endproperty
    a_route_rw: assert property (p_route_rw) else $error("routing readback wrong");

    property p_prio;
        can_b_en && can_a_en && route_reg[1:0] == 2'h0 |=> can_a_receive;
    endproperty
    a_prio: assert property (p_prio) else $error("pin priority wrong");

    property p_reset_pads;
        disable iff (1'b0)
        sys_rst |=> pads.oe == 8'h00 && pads.pull_up == 8'h00 && pads.pull_dn == 8'h00
            && dir_reg == 8'h00 && route_reg == 8'h00;
    endproperty
    a_reset_pads: assert property (p_reset_pads) else $error("reset state wrong");

    c_cana_mid: cover property (can_a_en && route_reg[1:0] == 2'h1 ##1 pads.oe[3]);
    c_spi_m: cover property (spi0_en && route_reg[4] ##1 pads.oe[5]);
    c_od_low: cover property (od_reg[7] && dir_reg[7] ##1 pads.oe[7] && !pads.out[7]);
    c_pull_dn: cover property (##1 pads.pull_dn != 8'h00);

endmodule : pmr_port

// [sim/pmr_pad_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Pads and the board wiring behind them
// ----------------------------------------
module pmr_pad_model (
    input wire logic sys_clk,
    input wire pmr_pkg::pmr_pad_s pads,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    logic float_reg = 1'b0;

    // A floating pin must not settle to a value the design could rely on
    always @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pads.oe[i]) begin
                pad_in[i] = pads.out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pads.pull_up[i]) begin
                pad_in[i] = 1'b1;
            end else if (pads.pull_dn[i]) begin
                pad_in[i] = 1'b0;
            end else begin
                pad_in[i] = float_reg;
            end
        end
    end
endmodule : pmr_pad_model

// [sim/test_pmr_port.sv]
`timescale 1ns/10ps
module test_pmr_port;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] pad_in;
    pmr_pkg::pmr_pad_s pads;
    logic [7:0] gpio_data = 8'h00;
    logic can_a_en = 1'b0, can_a_transmit = 1'b1, can_a_receive;
    logic can_b_en = 1'b0, can_b_transmit = 1'b0, can_b_receive;
    logic can_c_en = 1'b0, can_c_transmit = 1'b1, can_c_receive;
    logic [1:0] can_c_route;
    logic spi0_en = 1'b0;
    pmr_pkg::pmr_spi_s spi0_drive = 8'h00;
    logic [3:0] spi0_sense;
    logic spi0_on_port_m, spi1_on_port_h, spi2_on_port_h;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] ext_val = 8'h3c;
    int err_count = 0;
    int samples_checked = 0;

    always #50 sys_clk = ~sys_clk;

    pmr_port uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pad_in(pad_in), .pads(pads), .gpio_data(gpio_data), .can_a_en(can_a_en),
        .can_a_transmit(can_a_transmit), .can_a_receive(can_a_receive),
        .can_b_en(can_b_en), .can_b_transmit(can_b_transmit), .can_b_receive(can_b_receive),
        .can_c_en(can_c_en), .can_c_transmit(can_c_transmit), .can_c_receive(can_c_receive),
        .can_c_route(can_c_route), .spi0_en(spi0_en), .spi0_drive(spi0_drive),
        .spi0_sense(spi0_sense), .spi0_on_port_m(spi0_on_port_m),
        .spi1_on_port_h(spi1_on_port_h), .spi2_on_port_h(spi2_on_port_h));

    pmr_pad_model pad_model (.sys_clk(sys_clk), .pads(pads), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({32'h0, reg_rdata}, {32'h0, exp});
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic cfg(input logic [7:0] dir, red, pe, pol, od, route);
        wr(8'h12, dir);
        wr(8'h13, red);
        wr(8'h14, pe);
        wr(8'h15, pol);
        wr(8'h16, od);
        wr(8'h17, route);
    endtask : cfg

    task automatic pads_chk(input logic [7:0] oe, out, red, pu, pd);
        idle(2);
        chk(pads, {oe, out, red, pu, pd});
    endtask : pads_chk

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int a = 8'h12; a <= 8'h17; a++) begin
            rd_chk(a[7:0], 8'h00);
        end
        rd_chk(8'h11, 8'h3c);
        rd_chk(8'h20, 8'h00);
        for (int a = 8'h12; a <= 8'h16; a++) begin
            wr(a[7:0], 8'ha5 ^ a[7:0]);
            rd_chk(a[7:0], 8'ha5 ^ a[7:0]);
        end
        wr(8'h17, 8'hff);
        rd_chk(8'h17, 8'h7f);
        chk({37'h0, spi0_on_port_m, spi1_on_port_h, spi2_on_port_h}, 40'h7);
        // Write and read back to back, no idle cycle between the strobes
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h17;
        reg_wdata <= 8'h95;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({32'h0, reg_rdata}, 40'h15);
        cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        #1;
        chk({37'h0, spi0_on_port_m, spi1_on_port_h, spi2_on_port_h}, 40'h0);
        wr(8'h11, 8'hff);
        ext_val <= 8'hc3;
        idle(6);
        rd_chk(8'h11, 8'hc3);
    endtask : t_regs

    task automatic t_gpio();
        gpio_data <= 8'h5a;
        cfg(8'hff, 8'h0f, 8'hff, 8'h30, 8'hf0, 8'h00);
        pads_chk(8'haf, 8'h0a, 8'h0f, 8'hc0, 8'h30);
        idle(6);
        rd_chk(8'h11, 8'h4a);
        cfg(8'h00, 8'hff, 8'hff, 8'h30, 8'h00, 8'h00);
        pads_chk(8'h00, 8'h5a, 8'h00, 8'hcf, 8'h30);
        cfg(8'hff, 8'h00, 8'hff, 8'h30, 8'h00, 8'h00);
        pads_chk(8'hff, 8'h5a, 8'h00, 8'h00, 8'h00);
        gpio_data <= 8'h00;
    endtask : t_gpio

    // Routing code c puts receive on pin 2c for CAN A and 2c+2 for CAN C, or nowhere for the unused codes
    task automatic t_can(input logic is_c);
        logic [7:0] rxm;
        for (int c = 0; c < 4; c++) begin
            rxm = is_c ? ((c == 1) ? 8'h10 : (c == 2) ? 8'h40 : 8'h00)
                       : ((c < 3) ? (8'h01 << (2 * c)) : 8'h00);
            cfg(8'hff, 8'h00, 8'h00, 8'h00, 8'h00, is_c ? 8'(c << 2) : 8'(c));
            can_a_en <= !is_c;
            can_c_en <= is_c;
            ext_val <= ~rxm;
            idle(8);
            pads_chk(~rxm, rxm << 1, 8'h00, 8'h00, 8'h00);
            chk({39'h0, is_c ? can_c_receive : can_a_receive}, {39'h0, rxm == 8'h00});
            if (is_c) chk({38'h0, can_c_route}, 40'(c));
            rd_chk(8'h12, 8'hff);
        end
        cfg(8'hff, 8'h00, 8'h00, 8'h00, is_c ? 8'h20 : 8'h08, is_c ? 8'h04 : 8'h01);
        pads_chk(is_c ? 8'hcf : 8'hf3, 8'h00, 8'h00, 8'h00, 8'h00);
        can_a_en <= 1'b0;
        can_c_en <= 1'b0;
        pads_chk(8'hff, 8'h00, 8'h00, 8'h00, 8'h00);
    endtask : t_can

    task automatic t_prio();
        can_b_en <= 1'b1;
        can_a_en <= 1'b1;
        cfg(8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00);
        ext_val <= 8'hfe;
        idle(8);
        pads_chk(8'h02, 8'h00, 8'h00, 8'h01, 8'hfc);
        chk({38'h0, can_b_receive, can_a_receive}, 40'h1);
        can_c_en <= 1'b1;
        cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06);
        // Second CAN lets go while the first sits elsewhere, so pin 1 returns to GPIO
        can_b_en <= 1'b0;
        ext_val <= 8'hef;
        idle(8);
        chk({38'h0, can_a_receive, can_c_receive}, 40'h1);
        can_a_en <= 1'b0;
        can_c_en <= 1'b0;
    endtask : t_prio

    task automatic t_spi();
        cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
        spi0_drive <= 8'he5;
        spi0_en <= 1'b1;
        ext_val <= 8'hfb;
        idle(8);
        pads_chk(8'h38, 8'h24, 8'h00, 8'h00, 8'h00);
        chk({35'h0, spi0_on_port_m, spi0_sense}, 40'h14);
        wr(8'h17, 8'h00);
        idle(8);
        pads_chk(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        chk({35'h0, spi0_on_port_m, spi0_sense}, 40'h00);
        spi0_en <= 1'b0;
    endtask : t_spi

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        repeat (9) @(posedge sys_clk);
        #1;
        chk(pads, 40'h0);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_gpio();
        t_can(1'b0);
        t_can(1'b1);
        t_prio();
        t_spi();
        results();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        err_count++;
        results();
    end
endmodule : test_pmr_port
